// File: slt_lane_ctrl.v
`include "slt_defines.vh"
`default_nettype none
// Operation
// [RQ1] RX coding reset waits for user ready
// [RQ2] RX analog done low during analog reset
// [RQ3] Count clear zeroes checker error counter
// [RQ4] Pattern error output is not sticky
// [RQ5] RX select: off, PRBS 7/15/23/31
// [RQ6] Self-seeded checker, errors come in bursts
// [RQ7] RX done low on full reset, needs ready
// [RQ8] TX buffer error sticky until buffer reset
// [RQ9] TX buffer half-full status bit
// [RQ10] Inhibit forces positive 0, negative 1
// [RQ11] TX coding reset leaves analog alone
// [RQ12] TX analog reset resets both layers
// [RQ13] Polarity swaps positive and negative outputs
// [RQ14] Error inject only when generator on
// [RQ15] TX select: off, PRBS 7/15/23/31
// [RQ16] TX done low on full reset, needs ready
// [RQ17] Resets are requested high, start at release
module slt_lane_ctrl (
   // Clock and reset
   input wire clk_i,
   input wire rstn_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   output wire irq_o,
   // Asynchronous reset requests and ready levels
   input wire rx_full_reset_i,
   input wire rx_pcs_reset_i,
   input wire rx_pma_reset_i,
   input wire tx_full_reset_i,
   input wire tx_pcs_reset_i,
   input wire tx_pma_reset_i,
   input wire rx_user_rdy_i,
   input wire tx_user_rdy_i,
   // Reset completion
   output wire rx_pma_done_o,
   output wire rx_done_o,
   output wire tx_done_o,
   // Receive serial stream and checker status
   input wire rx_serial_i,
   output wire rx_pat_err_o,
   // Transmit words and serial pair
   input wire [7:0] tx_parallel_word_i,
   input wire tx_word_valid_i,
   output wire [1:0] tx_buf_status_o,
   output wire serial_out_pos_o,
   output wire serial_out_neg_o
);

   // ****************************************
   // Constants
   // ****************************************
   localparam integer RST_CYC_I = (`SLT_RST_NS * `SLT_CLK_MHZ + 999) / 1000;
   localparam [3:0] RST_CYC = RST_CYC_I[3:0]; // Least time rounds up

   // ****************************************
   // Functions
   // ****************************************
   // Feedback tap of the selected polynomial, zero when off
   function prbs_fb;
      input [30:0] s;
      input [2:0] sel;
      begin
         case (sel)
            `SLT_PAT_P7: prbs_fb = s[6] ^ s[5];
            `SLT_PAT_P15: prbs_fb = s[14] ^ s[13];
            `SLT_PAT_P23: prbs_fb = s[22] ^ s[17];
            `SLT_PAT_P31: prbs_fb = s[30] ^ s[27];
            default: prbs_fb = 1'b0;
         endcase
      end
   endfunction

   // ****************************************
   // Input synchronisers
   // ****************************************
   wire [8:0] async_in;
   reg [8:0] sync1_q; // First stage, read by second stage only
   reg [8:0] sync2_q; // Safe to use
   assign async_in = {rx_full_reset_i, rx_pcs_reset_i, rx_pma_reset_i,
                      tx_full_reset_i, tx_pcs_reset_i, tx_pma_reset_i,
                      rx_user_rdy_i, tx_user_rdy_i, rx_serial_i};

   // Two flops for every asynchronous pin input
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_q <= 9'h000;
         sync2_q <= 9'h000;
      end else begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
      end
   end

   wire rx_full_s = sync2_q[8];
   wire rx_pcs_s = sync2_q[7];
   wire rx_pma_s = sync2_q[6];
   wire tx_full_s = sync2_q[5];
   wire tx_pcs_s = sync2_q[4];
   wire tx_pma_s = sync2_q[3];
   wire rx_rdy_s = sync2_q[2];
   wire tx_rdy_s = sync2_q[1];
   wire rx_bit_s = sync2_q[0];

   // ****************************************
   // Register file state
   // ****************************************
   reg [11:0] ctrl_q; // Test controls
   reg [3:0] ists_q; // Sticky events
   reg [3:0] ien_q; // Event enables
   reg [31:0] prdata_q;
   reg pready_q;
   reg pslverr_q;
   reg irq_q;
   wire [2:0] rx_sel = ctrl_q[`SLT_CTRL_RXSEL];
   wire [2:0] tx_sel = ctrl_q[`SLT_CTRL_TXSEL];

   // ****************************************
   // Reset sequencing
   // ****************************************
   reg [3:0] rx_pma_cnt_q;
   reg [3:0] rx_pcs_cnt_q;
   reg rx_pcs_pend_q; // Released, waiting for ready
   reg [3:0] tx_pma_cnt_q;
   reg [3:0] tx_pcs_cnt_q;
   reg rx_pma_done_q;
   reg rx_done_q;
   reg tx_done_q;

   // Analog path covers full or analog request; coding path full or coding request, plus analog on TX
   wire rx_pma_req = rx_full_s | rx_pma_s;
   wire rx_pcs_req = rx_full_s | rx_pcs_s;
   wire tx_pma_req = tx_full_s | tx_pma_s;
   wire tx_pcs_req = tx_full_s | tx_pma_s | tx_pcs_s; // [RQ12]
   wire rx_pma_busy = rx_pma_req | (rx_pma_cnt_q != 4'h0);
   wire rx_pcs_busy = rx_pcs_req | rx_pcs_pend_q | (rx_pcs_cnt_q != 4'h0);
   wire tx_pma_busy = tx_pma_req | (tx_pma_cnt_q != 4'h0);
   wire tx_pcs_busy = tx_pcs_req | (tx_pcs_cnt_q != 4'h0);

   // Counters reload while held (RX coding counter at ready after release) and then count down
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_pma_cnt_q <= 4'h0;
         rx_pcs_cnt_q <= 4'h0;
         rx_pcs_pend_q <= 1'b0;
         tx_pma_cnt_q <= 4'h0;
         tx_pcs_cnt_q <= 4'h0;
      end else begin
         // Sequence runs from the release of the request
         if (rx_pma_req) begin
            rx_pma_cnt_q <= RST_CYC; // [RQ17]
         end else if (rx_pma_cnt_q != 4'h0) begin
            rx_pma_cnt_q <= rx_pma_cnt_q - 4'h1;
         end
         // Coding reset held pending until user ready
         if (rx_pcs_req) begin
            rx_pcs_pend_q <= 1'b1;
         end else if (rx_pcs_pend_q && rx_rdy_s) begin
            rx_pcs_pend_q <= 1'b0; // [RQ1]
            rx_pcs_cnt_q <= RST_CYC; // [RQ1]
         end else if (rx_pcs_cnt_q != 4'h0) begin
            rx_pcs_cnt_q <= rx_pcs_cnt_q - 4'h1;
         end
         // Coding-only request never touches the analog counter
         if (tx_pma_req) begin
            tx_pma_cnt_q <= RST_CYC; // [RQ11]
         end else if (tx_pma_cnt_q != 4'h0) begin
            tx_pma_cnt_q <= tx_pma_cnt_q - 4'h1;
         end
         if (tx_pcs_req) begin
            tx_pcs_cnt_q <= RST_CYC; // [RQ12]
         end else if (tx_pcs_cnt_q != 4'h0) begin
            tx_pcs_cnt_q <= tx_pcs_cnt_q - 4'h1;
         end
      end
   end

   // Completion flags
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_pma_done_q <= 1'b0;
         rx_done_q <= 1'b0;
         tx_done_q <= 1'b0;
      end else begin
         rx_pma_done_q <= ~rx_pma_busy; // [RQ2]
         if (rx_full_s) begin
            rx_done_q <= 1'b0; // [RQ7]
         end else if (!rx_pma_busy && !rx_pcs_busy && rx_rdy_s) begin
            rx_done_q <= 1'b1; // [RQ7]
         end
         if (tx_full_s) begin
            tx_done_q <= 1'b0; // [RQ16]
         end else if (!tx_pma_busy && !tx_pcs_busy && tx_rdy_s) begin
            tx_done_q <= 1'b1; // [RQ16]
         end
      end
   end

   // ****************************************
   // Transmit FIFO and serializer
   // ****************************************
   reg [7:0] fifo_q [0:7]; // Word storage
   reg [2:0] wr_ptr_q;
   reg [2:0] rd_ptr_q;
   reg [3:0] fill_q;
   reg [7:0] shift_q; // Word being sent, msb first
   reg [2:0] bit_cnt_q;
   reg buf_err_q;
   reg half_q;
   wire fifo_full = fill_q[3];
   wire fifo_empty = (fill_q == 4'h0);
   wire need_word = (bit_cnt_q == 3'h0) && (tx_sel == `SLT_PAT_OFF);
   wire do_pop = need_word && !fifo_empty;
   wire do_push = tx_word_valid_i && !fifo_full;
   // Overrun drops the word; underrun sends zeros
   wire buf_fault = (tx_word_valid_i && fifo_full) || (need_word && fifo_empty);
   integer k;

   // Buffer is emptied by any TX coding-layer reset
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr_q <= 3'h0;
         rd_ptr_q <= 3'h0;
         fill_q <= 4'h0;
         shift_q <= 8'h00;
         bit_cnt_q <= 3'h0;
         buf_err_q <= 1'b0;
         half_q <= 1'b0;
         for (k = 0; k < 8; k = k + 1) begin
            fifo_q[k] <= 8'h00;
         end
      end else if (tx_pcs_busy) begin
         wr_ptr_q <= 3'h0;
         rd_ptr_q <= 3'h0;
         fill_q <= 4'h0;
         bit_cnt_q <= 3'h0;
         buf_err_q <= 1'b0; // [RQ8]
         half_q <= 1'b0;
      end else begin
         if (do_push) begin
            fifo_q[wr_ptr_q] <= tx_parallel_word_i;
            wr_ptr_q <= wr_ptr_q + 3'h1;
         end
         if (do_pop) begin
            rd_ptr_q <= rd_ptr_q + 3'h1;
            shift_q <= fifo_q[rd_ptr_q];
         end else begin
            shift_q <= {shift_q[6:0], 1'b0};
         end
         fill_q <= fill_q + {3'h0, do_push} - {3'h0, do_pop};
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (buf_fault) begin
            buf_err_q <= 1'b1; // [RQ8]
         end
         half_q <= ((fill_q + {3'h0, do_push} - {3'h0, do_pop}) >= `SLT_FIFO_HALF); // [RQ9]
      end
   end

   // ****************************************
   // Pattern generator and line driver
   // ****************************************
   reg [30:0] gen_q;
   reg pos_q;
   reg neg_q;
   wire gen_bit = prbs_fb(gen_q, tx_sel); // [RQ15]
   // Injection flips the line bit but not the generator state
   wire tx_bit = (tx_sel != `SLT_PAT_OFF) ?
                 (gen_bit ^ ctrl_q[`SLT_CTRL_FERR]) : shift_q[7]; // [RQ14]
   wire line_bit = tx_bit ^ ctrl_q[`SLT_CTRL_POL]; // [RQ13]

   // Generator parks at seed on coding reset and while off
   // Parking matters: shifting zeros while off would lock the register at zero
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gen_q <= `SLT_SEED;
         pos_q <= 1'b0;
         neg_q <= 1'b1;
      end else begin
         if (tx_pcs_busy || (tx_sel == `SLT_PAT_OFF)) begin
            gen_q <= `SLT_SEED; // [RQ15]
         end else begin
            gen_q <= {gen_q[29:0], gen_bit};
         end
         // Analog reset idles the pair like inhibit
         if (ctrl_q[`SLT_CTRL_INH] || tx_pma_busy) begin
            pos_q <= 1'b0; // [RQ10]
            neg_q <= 1'b1; // [RQ10]
         end else begin
            pos_q <= line_bit; // [RQ13]
            neg_q <= ~line_bit; // [RQ13]
         end
      end
   end

   // ****************************************
   // Pattern checker
   // ****************************************
   reg [30:0] chk_q; // Last received bits
   reg err_q;
   reg [15:0] ecnt_q;
   // Expected bit comes from received history, not a local seed
   wire chk_on = (rx_sel != `SLT_PAT_OFF) && !rx_pcs_busy; // [RQ5]
   wire mism = chk_on && (rx_bit_s ^ prbs_fb(chk_q, rx_sel)); // [RQ6]

   // Error flag follows each bit, counter saturates
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         chk_q <= 31'h00000000;
         err_q <= 1'b0;
         ecnt_q <= 16'h0000;
      end else begin
         chk_q <= {chk_q[29:0], rx_bit_s}; // [RQ6]
         err_q <= mism; // [RQ4]
         if (ctrl_q[`SLT_CTRL_CCLR] || rx_pcs_busy) begin
            ecnt_q <= 16'h0000; // [RQ3]
         end else if (mism && (ecnt_q != 16'hffff)) begin
            ecnt_q <= ecnt_q + 16'h0001;
         end
      end
   end

   // ****************************************
   // APB slave and interrupts
   // ****************************************
   wire acc = psel_i && penable_i && !pready_q; // Access first cycle
   wire done = psel_i && penable_i && pready_q; // Transfer edge
   wire wr = done && pwrite_i;
   reg rx_done_d1_q;
   reg tx_done_d1_q;
   reg buf_err_d1_q;
   // Events: pattern error, buffer fault, RX done rise, TX done rise
   wire [3:0] ev = {tx_done_q & ~tx_done_d1_q, rx_done_q & ~rx_done_d1_q,
                    buf_err_q & ~buf_err_d1_q, err_q};
   wire [3:0] ists_d = (ists_q & ~((wr && paddr_i == `SLT_OFS_ICLR) ?
                        pwdata_i[3:0] : 4'h0)) | ev; // Set beats clear
   reg [31:0] rd_mux;
   reg hit;

   // Read decode
   always @* begin
      rd_mux = 32'h00000000;
      hit = 1'b1;
      case (paddr_i)
         `SLT_OFS_CTRL: rd_mux = {20'h00000, ctrl_q};
         `SLT_OFS_STAT: rd_mux = {26'h0000000, buf_err_q,
                                  half_q, err_q, tx_done_q, rx_done_q,
                                  rx_pma_done_q};
         `SLT_OFS_ECNT: rd_mux = {16'h0000, ecnt_q};
         `SLT_OFS_ISTS: rd_mux = {28'h0000000, ists_q};
         `SLT_OFS_IEN: rd_mux = {28'h0000000, ien_q};
         `SLT_OFS_ICLR: rd_mux = 32'h00000000; // Write-only
         default: hit = 1'b0;
      endcase
   end

   // One wait state, then answer and write at the same edge
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_q <= `SLT_CTRL_RST;
         ists_q <= 4'h0;
         ien_q <= 4'h0;
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
         rx_done_d1_q <= 1'b0;
         tx_done_d1_q <= 1'b0;
         buf_err_d1_q <= 1'b0;
      end else begin
         pready_q <= acc;
         // Error stands only beside ready, never beyond it
         pslverr_q <= acc && !hit;
         if (acc) begin
            prdata_q <= pwrite_i ? 32'h00000000 : rd_mux;
         end
         if (wr && paddr_i == `SLT_OFS_CTRL) begin
            ctrl_q <= pwdata_i[11:0];
         end
         if (wr && paddr_i == `SLT_OFS_IEN) begin
            ien_q <= pwdata_i[3:0];
         end
         ists_q <= ists_d;
         irq_q <= |(ists_d & ien_q);
         rx_done_d1_q <= rx_done_q;
         tx_done_d1_q <= tx_done_q;
         buf_err_d1_q <= buf_err_q;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign irq_o = irq_q;
   assign rx_pma_done_o = rx_pma_done_q;
   assign rx_done_o = rx_done_q;
   assign tx_done_o = tx_done_q;
   assign rx_pat_err_o = err_q;
   assign tx_buf_status_o = {buf_err_q, half_q};
   assign serial_out_pos_o = pos_q;
   assign serial_out_neg_o = neg_q;

endmodule // slt_lane_ctrl
`default_nettype wire

// File: slt_defines.vh
`ifndef SLT_DEFINES_VH
`define SLT_DEFINES_VH
// ****************************************
// Register byte offsets
// ****************************************
`define SLT_OFS_CTRL 8'h00
`define SLT_OFS_STAT 8'h04
`define SLT_OFS_ECNT 8'h08
`define SLT_OFS_ISTS 8'h0c
`define SLT_OFS_IEN 8'h10
`define SLT_OFS_ICLR 8'h14
// ****************************************
// Control register fields
// ****************************************
`define SLT_CTRL_RXSEL 2:0
`define SLT_CTRL_TXSEL 6:4
`define SLT_CTRL_INH 8
`define SLT_CTRL_POL 9
`define SLT_CTRL_FERR 10
`define SLT_CTRL_CCLR 11
`define SLT_CTRL_RST 12'h000
// ****************************************
// Pattern select codes
// ****************************************
`define SLT_PAT_OFF 3'h0
`define SLT_PAT_P7 3'h1
`define SLT_PAT_P15 3'h2
`define SLT_PAT_P23 3'h3
`define SLT_PAT_P31 3'h4
// ****************************************
// Timing and sizes
// ****************************************
`define SLT_CLK_MHZ 100
`define SLT_RST_NS 100
`define SLT_FIFO_HALF 4'h4
`define SLT_SEED 31'h7fffffff
`endif

// File: slt_fabric_model.sv
`default_nettype none
// ****************************************
// Loopback wiring of the fabric side
// ****************************************
module slt_fabric_model (
   // Clock
   input wire logic clk_i,
   // Line pair from the lane
   input wire logic serial_out_pos_i,
   input wire logic serial_out_neg_i,
   // Commands from the bench
   input wire logic use_neg_i,
   input wire logic flip_i,
   // Stream back into the receiver
   output logic rx_serial_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Registered loop, so one flip corrupts exactly one line bit
   always @(posedge clk_i) begin
      rx_serial_o <= (use_neg_i ? serial_out_neg_i : serial_out_pos_i) ^ flip_i;
   end
endmodule // slt_fabric_model
`default_nettype wire

// File: slt_lane_ctrl_properties.sv
`default_nettype none
// ****************************************
// Port checker of the lane block
// ****************************************
module slt_lane_ctrl_properties (
   // Clock and reset
   input wire clk_i,
   input wire rstn_i,
   // Bus answer
   input wire pready_o,
   input wire pslverr_o,
   // Reset requests and ready levels
   input wire rx_full_reset_i,
   input wire rx_pma_reset_i,
   input wire tx_full_reset_i,
   input wire tx_pcs_reset_i,
   input wire tx_pma_reset_i,
   input wire rx_user_rdy_i,
   input wire tx_user_rdy_i,
   // Status outputs
   input wire rx_pma_done_o,
   input wire rx_done_o,
   input wire tx_done_o,
   input wire [1:0] tx_buf_status_o,
   input wire serial_out_pos_o,
   input wire serial_out_neg_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Five cycles cover the two-flop sync plus the output register
   sequence s_tx_quiet;
      (!tx_pcs_reset_i && !tx_pma_reset_i && !tx_full_reset_i)[*5];
   endsequence
   a_line_compl: assert property (serial_out_pos_o != serial_out_neg_o)
      else $error("line pair not complementary");
   a_pma_idle_line: assert property (tx_pma_reset_i[*5] |-> !serial_out_pos_o && serial_out_neg_o)
      else $error("line not idle in analog reset");
   a_rx_pma_low: assert property ((rx_pma_reset_i || rx_full_reset_i)[*5] |-> !rx_pma_done_o)
      else $error("analog done high in reset");
   a_rx_done_low: assert property (rx_full_reset_i[*5] |-> !rx_done_o)
      else $error("rx done high in full reset");
   a_rx_done_wait: assert property (!rx_user_rdy_i[*5] |-> !$rose(rx_done_o))
      else $error("rx done rose without ready");
   a_tx_done_low: assert property (tx_full_reset_i[*5] |-> !tx_done_o)
      else $error("tx done high in full reset");
   a_tx_done_wait: assert property (!tx_user_rdy_i[*5] |-> !$rose(tx_done_o))
      else $error("tx done rose without ready");
   a_buf_err_sticky: assert property (s_tx_quiet ##0 tx_buf_status_o[1] |=> tx_buf_status_o[1])
      else $error("buffer error dropped");
   a_buf_flush: assert property (tx_pcs_reset_i[*5] |-> tx_buf_status_o == 2'h0)
      else $error("buffer not flushed");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_slverr_qual: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
endmodule // slt_lane_ctrl_properties
bind slt_lane_ctrl slt_lane_ctrl_properties slt_lane_ctrl_properties_inst (
   .clk_i(clk_i), .rstn_i(rstn_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .rx_full_reset_i(rx_full_reset_i), .rx_pma_reset_i(rx_pma_reset_i),
   .tx_full_reset_i(tx_full_reset_i), .tx_pcs_reset_i(tx_pcs_reset_i),
   .tx_pma_reset_i(tx_pma_reset_i), .rx_user_rdy_i(rx_user_rdy_i),
   .tx_user_rdy_i(tx_user_rdy_i), .rx_pma_done_o(rx_pma_done_o), .rx_done_o(rx_done_o),
   .tx_done_o(tx_done_o), .tx_buf_status_o(tx_buf_status_o),
   .serial_out_pos_o(serial_out_pos_o), .serial_out_neg_o(serial_out_neg_o));
`default_nettype wire

// File: serdes_lane_test_reset_ctrl_tb.sv
`include "slt_defines.vh"
`default_nettype none
module serdes_lane_test_reset_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Signals
   // ****************************************
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, word = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic pready, pslverr, irq, e, rxrdy = 0, txrdy = 0, vld = 0, flip = 0, useneg = 0;
   logic [5:0] rq = 6'h00; // rx full, pcs, pma, tx full, pcs, pma
   logic rxpd, rxd, txd, rxser, perr, pos, neg;
   logic [1:0] bst;
   int bad_count = 0, check_count = 0, cyc = 0;
   int ones = 0, t = 0; // Ones seen on the positive line
   slt_lane_ctrl slt_lane_ctrl_inst (.clk_i(clk), .rstn_i(rstn), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
      .rx_full_reset_i(rq[0]), .rx_pcs_reset_i(rq[1]), .rx_pma_reset_i(rq[2]),
      .tx_full_reset_i(rq[3]), .tx_pcs_reset_i(rq[4]), .tx_pma_reset_i(rq[5]),
      .rx_user_rdy_i(rxrdy), .tx_user_rdy_i(txrdy), .rx_pma_done_o(rxpd),
      .rx_done_o(rxd), .tx_done_o(txd), .rx_serial_i(rxser), .rx_pat_err_o(perr),
      .tx_parallel_word_i(word), .tx_word_valid_i(vld), .tx_buf_status_o(bst),
      .serial_out_pos_o(pos), .serial_out_neg_o(neg));
   slt_fabric_model slt_fabric_model_inst (.clk_i(clk), .serial_out_pos_i(pos),
      .serial_out_neg_i(neg), .use_neg_i(useneg), .flip_i(flip), .rx_serial_o(rxser));
   // ****************************************
   // Clock, timeout and closing
   // ****************************************
   initial begin
      forever #5 clk = ~clk;
   end
   // Hang guard, about five times the expected run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   // Ones on the positive line, unknowns not counted
   always @(posedge clk) begin
      ones <= ones + (pos === 1'b1);
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ****************************************
   // Bus tasks and compare
   // ****************************************
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   // Request held until ready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk); // Idle edge, so no strobe is set twice in one step
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      cmp(d & m, x);
   endtask
   // Held high, then released to start the sequence
   task automatic pulse(input int i);
      rq[i] <= 1;
      w(6);
      rq[i] <= 0;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      w(6);
      rstn <= 1;
      w(1);
      rdc(`SLT_OFS_CTRL, 32'h0, 32'hffffffff);
      rdc(`SLT_OFS_ICLR, 32'h0, 32'hffffffff);
      rdc(8'h18, 32'h0, 32'hffffffff);
      cmp(e, 1);
      // Receive resets, ready held low first
      pulse(0);
      w(30);
      cmp(rxd, 0);
      cmp(rxpd, 1);
      rxrdy <= 1;
      w(30);
      cmp(rxd, 1);
      rq[2] <= 1;
      w(6);
      cmp(rxpd, 0);
      rq[2] <= 0;
      w(30);
      cmp(rxpd, 1);
      // Transmit reset, then buffer fill in word mode
      txrdy <= 1;
      pulse(3);
      w(40);
      cmp(txd, 1);
      cmp(bst[1], 1);
      vld <= 1;
      for (int k = 0; k < 9; k++) begin
         word <= 8'ha5 ^ k[7:0];
         w(1);
      end
      vld <= 0;
      w(1);
      cmp(bst, 2'h3);
      w(100);
      cmp(bst, 2'h2);
      wr(`SLT_OFS_CTRL, 32'h200);
      rq[4] <= 1;
      w(6);
      cmp(bst, 2'h0);
      cmp({pos, neg}, 2'h2);
      rq[4] <= 0;
      rq[5] <= 1;
      w(6);
      cmp({pos, neg}, 2'h1);
      rq[5] <= 0;
      w(30);
      // Each PRBS code, clean then one flipped bit
      for (int c = 1; c <= 4; c++) begin
         wr(`SLT_OFS_CTRL, 32'h800 | (c << 4) | c);
         w(100);
         wr(`SLT_OFS_CTRL, (c << 4) | c);
         t = ones;
         w(100);
         cmp(ones - t > 20, 1);
         rdc(`SLT_OFS_ECNT, 32'h0, 32'hffff);
         flip <= 1;
         w(1);
         flip <= 0;
         w(60);
         apb(1'b0, `SLT_OFS_ECNT, 32'h0);
         cmp(d > 1, 1);
         rdc(`SLT_OFS_STAT, 32'h0, 32'h8);
         wr(`SLT_OFS_CTRL, 32'h800 | (c << 4) | c);
         rdc(`SLT_OFS_ECNT, 32'h0, 32'hffff);
      end
      // Injection with generator off leaves the line quiet
      wr(`SLT_OFS_CTRL, 32'h400);
      w(2);
      t = ones;
      w(20);
      cmp(ones - t, 0);
      // Injection with checker off, then on, with interrupt
      wr(`SLT_OFS_CTRL, 32'h410);
      w(20);
      wr(`SLT_OFS_CTRL, 32'h010);
      rdc(`SLT_OFS_ECNT, 32'h0, 32'hffff);
      wr(`SLT_OFS_CTRL, 32'h811);
      w(100);
      wr(`SLT_OFS_CTRL, 32'h011);
      wr(`SLT_OFS_IEN, 32'h1);
      wr(`SLT_OFS_ICLR, 32'h1);
      w(100);
      wr(`SLT_OFS_CTRL, 32'h411);
      wr(`SLT_OFS_CTRL, 32'h011);
      w(60);
      apb(1'b0, `SLT_OFS_ECNT, 32'h0);
      cmp(d != 0, 1);
      cmp(irq, 1);
      wr(`SLT_OFS_IEN, 32'h0);
      w(2);
      cmp(irq, 0);
      wr(`SLT_OFS_IEN, 32'h1);
      w(2);
      cmp(irq, 1);
      wr(`SLT_OFS_ICLR, 32'h1);
      w(2);
      cmp(irq, 0);
      rdc(`SLT_OFS_ISTS, 32'h0, 32'h1);
      // Swapped pair read from the negative line
      useneg <= 1;
      wr(`SLT_OFS_CTRL, 32'ha11);
      w(100);
      wr(`SLT_OFS_CTRL, 32'h211);
      w(100);
      rdc(`SLT_OFS_ECNT, 32'h0, 32'hffff);
      useneg <= 0;
      // Inhibit holds the idle pair
      wr(`SLT_OFS_CTRL, 32'h111);
      w(4);
      for (int k = 0; k < 8; k++) begin
         w(1);
         cmp({pos, neg}, 2'h1);
      end
      tally_and_finish();
   end
endmodule // serdes_lane_test_reset_ctrl_tb
`default_nettype wire
